// ### include/ssp_consts.svh
/*
  constants of the serial port control block: register indexes, field positions,
  mode codes and timing figures. assumes a 100 MHz pclk.
*/
`ifndef SSP_CONSTS_SVH
`define SSP_CONSTS_SVH

// register indexes; byte address is four times the index
`define IDX_BUF       12'h18c
`define IDX_CON1      12'h190
`define IDX_CON2      12'h191
`define IDX_CON3      12'h192
`define IDX_STAT      12'h193
`define IDX_IRQ_STAT  12'h194
`define IDX_IRQ_MASK  12'h195

`define RST_BYTE      8'h00
`define RST_NIB       4'h0

// control one fields
`define C1_WCOL       7
`define C1_OVF        6
`define C1_EN         5
`define C1_CKR        4

// control two fields
`define C2_GCEN       7
`define C2_ACKSTAT    6
`define C2_ACK_DATA_VALUE      5
`define C2_ACKEN      4
`define C2_RCEN       3
`define C2_PEN        2
`define C2_RSEN       1
`define C2_SEN        0

// control three fields
`define C3_ACK_PHASE_STATUS     7
`define C3_PCIE       6
`define C3_START_IRQ_ENABLE       5
`define C3_BUFFER_OVERWRITE_ENABLE       4
`define C3_DATA_HOLD_SELECT      3
`define C3_SLAVE_COLLISION_DETECT_ENABLE      2
`define C3_ADDRESS_STRETCH_ENABLE       1
`define C3_DATA_STRETCH_ENABLE       0

// interrupt status bits
`define IRQ_START     0
`define IRQ_STOP      1
`define IRQ_BYTE      2
`define IRQ_COLL      3

// mode codes
`define MODE_SL10_SS  4'hf
`define MODE_SL7_SS   4'he
`define MODE_SL10     4'h7
`define MODE_SL7      4'h6
`define MODE_MST      4'h8
`define MODE_MST_FW   4'hb

// bit counts
`define BITS_BYTE     4'h8
`define BITS_ACK      4'h9
`define SPI_LAST      3'h7

// timing
`define CLK_NS        10
`define HOLD_LONG_NS  300
`define HOLD_SHORT_NS 100
`define PHASE_NS      5000
`define HOLD_LONG_CYC  ((`HOLD_LONG_NS + `CLK_NS - 1) / `CLK_NS)
`define HOLD_SHORT_CYC ((`HOLD_SHORT_NS + `CLK_NS - 1) / `CLK_NS)
`define PHASE_CYC      (`PHASE_NS / `CLK_NS)

`endif

// ### include/ssp_pkg.sv
/*
  types of the serial port control block.
  assumes nothing of its surroundings.
*/
package ssp_pkg;

  typedef enum logic [1:0] {
    M_IDLE   = 2'b00,
    M_START  = 2'b01,
    M_ACK_LO = 2'b11,
    M_ACK_HI = 2'b10
  } mst_state_t;

endpackage : ssp_pkg

// ### core/ssp_pin_sync.sv
/*
  three-flop synchroniser with agreement filter for pins.
  assumes pins are asynchronous to pclk.
*/
`timescale 1ns/1ps
module ssp_pin_sync import ssp_pkg::*; #(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // pins in, filtered levels out
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] lvl
);

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic s1_r;
      logic s2_r;
      logic s3_r;
      logic lvl_r;
      // first stage feeds only the second
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_r  <= 1'b1;
          s2_r  <= 1'b1;
          s3_r  <= 1'b1;
          lvl_r <= 1'b1;
        end else begin
          s1_r <= pin[i];
          s2_r <= s1_r;
          s3_r <= s2_r;
          if (s2_r == s3_r) begin
            lvl_r <= s3_r;
          end
        end
      end
      assign lvl[i] = lvl_r;
    end
  endgenerate

endmodule : ssp_pin_sync

// ### core/ssp_hold_timer.sv
/*
  data-line hold timer: a pulse after the selected hold time.
  assumes start is a one-cycle pulse on a falling clock edge of the bus.
*/
`timescale 1ns/1ps
module ssp_hold_timer import ssp_pkg::*; #(
  parameter int LONG_CYC  = 30,
  parameter int SHORT_CYC = 10
) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // control
  input  wire logic start,
  input  wire logic long_sel,
  output logic      done
);

  logic [5:0] cnt_r;
  wire  [5:0] load_val = long_sel ? 6'(LONG_CYC) : 6'(SHORT_CYC);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 6'h00;
    end else if (start) begin
      cnt_r <= load_val;
    end else if (cnt_r != 6'h00) begin
      cnt_r <= cnt_r - 6'h01;
    end
  end

  // a retrigger restarts the count, so the newest edge always gets the full hold
  assign done = (cnt_r == 6'h01);

endmodule : ssp_hold_timer

// ### core/ssp_ctrl.sv
/*
  serial port core: APB registers, I2C slave byte engine with clock stretch,
  I2C master start and acknowledge sequencer, SPI receive and interrupts.
  assumes open-drain bus pins resolved outside and a 100 MHz pclk.
*/
// Function
// - start request makes start, then self-clears
// - master acknowledge drives the ack data value
// - busy engine refuses requests and buffer writes
// - ack phase status set at eighth fall when address or data hold is on
// - ack phase status cleared at ninth rise
// - ack phase status idle outside slave mode
// - stop interrupt when enabled outside two modes
// - start interrupt when enabled outside two modes
// - spi overwrite always stores, still flags overflow
// - spi no overwrite keeps buffer, flags overflow
// - i2c overwrite stores every byte
// - i2c no overwrite stores only without overflow
// - hold select sets data hold time
// - slave collision detect only in slave mode
// - address hold clears clock release
// - data hold clears clock release
// - clock release low stretches bus clock in slave mode
`timescale 1ns/1ps
`include "ssp_consts.svh"
module ssp_ctrl import ssp_pkg::*; #(
  parameter int PHASE_CYC = `PHASE_CYC
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [13:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // interrupt
  output logic             irq,
  // i2c pins, enables active low
  input  wire logic        serial_clock_line_in,
  output logic             serial_clock_line_out,
  output logic             serial_clock_line_oe_n,
  input  wire logic        serial_data_line_in,
  output logic             serial_data_line_out,
  output logic             serial_data_line_oe_n,
  // spi pins
  input  wire logic        spi_sck,
  input  wire logic        spi_sdi,
  output logic             spi_sdo
);

  function automatic logic is_slave(input logic [3:0] m);
    return (m == `MODE_SL10_SS) || (m == `MODE_SL7_SS) || (m == `MODE_SL10) || (m == `MODE_SL7);
  endfunction : is_slave

  function automatic logic is_master(input logic [3:0] m);
    return (m == `MODE_MST) || (m == `MODE_MST_FW);
  endfunction : is_master

  // registers
  logic [7:0] buf_r;
  logic       wcol_r, ovf_r, en_r, ckr_r, full_r;
  logic [3:0] mode_r;
  logic       gcen_r, ackstat_r, ack_data_value_r, acken_r, rcen_r, pen_r, rsen_r, sen_r;
  logic       ack_phase_r;
  logic [6:0] con3_r;
  logic [3:0] irq_stat_r, irq_mask_r;
  logic [7:0] prdata_r;
  logic       pslverr_r;

  // pins
  logic [3:0] lvl;
  logic       scl_q_r, sda_q_r, sck_q_r;
  ssp_pin_sync #(.W(4)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     ({spi_sdi, spi_sck, serial_data_line_in, serial_clock_line_in}),
    .lvl     (lvl)
  );
  wire scl      = lvl[0];
  wire sda      = lvl[1];
  wire sck      = lvl[2];
  wire sdi      = lvl[3];
  wire scl_rise = scl & ~scl_q_r;
  wire scl_fall = ~scl & scl_q_r;
  wire sck_rise = sck & ~sck_q_r;
  wire sck_fall = ~sck & sck_q_r;
  wire start_det = scl & scl_q_r & sda_q_r & ~sda;
  wire stop_det  = scl & scl_q_r & ~sda_q_r & sda;

  // mode decode
  wire slave_m  = en_r & is_slave(mode_r);
  wire master_m = en_r & is_master(mode_r);
  wire spi_m    = en_r & ~is_slave(mode_r) & ~is_master(mode_r);
  wire i2c_m    = slave_m | master_m;
  wire ss_mode  = (mode_r == `MODE_SL10_SS) || (mode_r == `MODE_SL10);
  wire buffer_overwrite_enable     = con3_r[`C3_BUFFER_OVERWRITE_ENABLE];
  wire data_hold_select    = con3_r[`C3_DATA_HOLD_SELECT];
  wire address_stretch_enable     = con3_r[`C3_ADDRESS_STRETCH_ENABLE];
  wire data_stretch_enable     = con3_r[`C3_DATA_STRETCH_ENABLE];

  // apb decode; the bus never waits, read data is captured in the setup cycle
  wire [11:0] idx    = paddr[13:2];
  wire        setup  = psel & ~penable;
  wire        access = psel & penable;
  wire        wr     = access & pwrite;
  wire        rd     = access & ~pwrite;
  wire        hit_buf = (idx == `IDX_BUF);
  wire        hit_c1  = (idx == `IDX_CON1);
  wire        hit_c2  = (idx == `IDX_CON2);
  wire        hit_c3  = (idx == `IDX_CON3);
  wire        hit_st  = (idx == `IDX_STAT);
  wire        hit_is  = (idx == `IDX_IRQ_STAT);
  wire        hit_im  = (idx == `IDX_IRQ_MASK);
  wire        mapped  = hit_buf | hit_c1 | hit_c2 | hit_c3 | hit_st | hit_is | hit_im;

  mst_state_t mst_r, mst_nxt;
  logic [9:0] ph_cnt_r;
  wire        active = (mst_r != M_IDLE);
  wire        ph_end = (ph_cnt_r == 10'(PHASE_CYC - 1));

  wire [7:0] rd_c1 = {wcol_r, ovf_r, en_r, ckr_r, mode_r};
  wire [7:0] rd_c2 = {gcen_r, ackstat_r, ack_data_value_r, acken_r, rcen_r, pen_r, rsen_r, sen_r};
  wire [7:0] rd_c3 = {ack_phase_r, con3_r};
  logic      in_frame_r, rd_mode_r;
  wire [7:0] rd_st = {4'h0, rd_mode_r, active, in_frame_r, full_r};
  wire [7:0] rd_mux = hit_buf ? buf_r : hit_c1 ? rd_c1 : hit_c2 ? rd_c2 : hit_c3 ? rd_c3 :
                      hit_st ? rd_st : hit_is ? {4'h0, irq_stat_r} :
                      hit_im ? {4'h0, irq_mask_r} : `RST_BYTE;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r  <= `RST_BYTE;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      prdata_r  <= rd_mux;
      pslverr_r <= ~mapped;
    end
  end
  assign prdata  = {24'h000000, prdata_r};
  assign pready  = 1'b1;
  assign pslverr = pslverr_r;

  // i2c slave byte engine
  logic [3:0] bit_cnt_r;
  logic [7:0] rx_sh_r, tx_sh_r;
  logic       addr_ph_r, pend_low_r, sda_low_r, hold_done;
  wire        rd_data = rd_mode_r & ~addr_ph_r;
  wire        fall8   = slave_m & in_frame_r & scl_fall & (bit_cnt_r == `BITS_BYTE);
  wire        fall9   = slave_m & in_frame_r & scl_fall & (bit_cnt_r == `BITS_ACK);
  wire        rise9   = slave_m & in_frame_r & scl_rise & (bit_cnt_r == `BITS_BYTE);
  wire        rise_bit = slave_m & in_frame_r & scl_rise & (bit_cnt_r < `BITS_BYTE);
  wire        fall_any = slave_m & in_frame_r & scl_fall;
  wire        stretch  = fall8 & ((addr_ph_r & address_stretch_enable) | (~addr_ph_r & data_stretch_enable));
  wire        i2c_store = fall8 & ~rd_data;
  wire        coll_ev = rise_bit & rd_data & ~pend_low_r & ~sda & con3_r[`C3_SLAVE_COLLISION_DETECT_ENABLE];

  ssp_hold_timer #(.LONG_CYC(`HOLD_LONG_CYC), .SHORT_CYC(`HOLD_SHORT_CYC)) u_hold (
    .pclk     (pclk),
    .presetn  (presetn),
    .start    (fall_any),
    .long_sel (data_hold_select),
    .done     (hold_done)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      // matches the synchroniser's reset level, so no false rising edge follows reset
      sck_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl;
      sda_q_r <= sda;
      sck_q_r <= sck;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_frame_r <= 1'b0;
      bit_cnt_r  <= `RST_NIB;
      addr_ph_r  <= 1'b0;
      rd_mode_r  <= 1'b0;
      rx_sh_r    <= `RST_BYTE;
      tx_sh_r    <= `RST_BYTE;
      pend_low_r <= 1'b0;
      sda_low_r  <= 1'b0;
    end else if (!slave_m || start_det || stop_det) begin
      in_frame_r <= slave_m & start_det;
      bit_cnt_r  <= `RST_NIB;
      addr_ph_r  <= 1'b1;
      rd_mode_r  <= 1'b0;
      pend_low_r <= 1'b0;
      sda_low_r  <= 1'b0;
    end else begin
      if (rise_bit) begin
        rx_sh_r   <= {rx_sh_r[6:0], sda};
        tx_sh_r   <= {tx_sh_r[6:0], 1'b0};
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end
      if (rise9) begin
        bit_cnt_r <= `BITS_ACK;
      end
      if (fall8) begin
        pend_low_r <= ~rd_data;
        if (addr_ph_r) begin
          rd_mode_r <= rx_sh_r[0];
        end
      end else if (fall9) begin
        bit_cnt_r  <= `RST_NIB;
        addr_ph_r  <= 1'b0;
        tx_sh_r    <= buf_r;
        pend_low_r <= rd_mode_r & ~buf_r[7];
      end else if (fall_any) begin
        pend_low_r <= rd_data & ~tx_sh_r[7];
      end
      // data line changes only once the hold after the falling edge has passed
      if (hold_done) begin
        sda_low_r <= pend_low_r;
      end
    end
  end

  // spi receive and transmit shifters
  logic [2:0] spi_cnt_r;
  logic [6:0] spi_sh_r;
  logic [7:0] spi_tx_r;
  wire        spi_done = spi_m & sck_rise & (spi_cnt_r == `SPI_LAST);
  wire [7:0]  spi_byte = {spi_sh_r, sdi};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spi_cnt_r <= 3'h0;
      spi_sh_r  <= 7'h00;
    end else if (!spi_m) begin
      spi_cnt_r <= 3'h0;
    end else if (sck_rise) begin
      spi_sh_r  <= spi_byte[6:0];
      spi_cnt_r <= spi_cnt_r + 3'h1;
    end
  end

  // buffer, full and overflow; the byte is stored according to the overwrite policy
  wire buf_wr   = wr & hit_buf & ~active;
  wire i2c_take = i2c_store & (buffer_overwrite_enable | ~ovf_r);
  wire spi_take = spi_done & (buffer_overwrite_enable | ~full_r);
  wire ovf_set  = (i2c_store | spi_done) & full_r;
  wire wcol_set = wr & hit_buf & active;
  wire full_set = i2c_store | spi_done;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_r    <= `RST_BYTE;
      spi_tx_r <= `RST_BYTE;
    end else begin
      if (buf_wr) begin
        buf_r    <= pwdata[7:0];
        spi_tx_r <= pwdata[7:0];
      end else if (i2c_take) begin
        buf_r <= rx_sh_r;
      end else if (spi_take) begin
        buf_r <= spi_byte;
      end else if (spi_m && sck_fall) begin
        spi_tx_r <= {spi_tx_r[6:0], 1'b0};
      end
    end
  end
  assign spi_sdo = spi_tx_r[7];

  // control one; hardware sets win over software clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wcol_r <= 1'b0;
      ovf_r  <= 1'b0;
      full_r <= 1'b0;
      en_r   <= 1'b0;
      ckr_r  <= 1'b0;
      mode_r <= `RST_NIB;
    end else begin
      wcol_r <= wcol_set | ((wr & hit_c1) ? pwdata[`C1_WCOL] : wcol_r);
      ovf_r  <= ovf_set | ((wr & hit_c1) ? pwdata[`C1_OVF] : ovf_r);
      full_r <= full_set | (full_r & ~(rd & hit_buf));
      if (wr && hit_c1) begin
        en_r   <= pwdata[`C1_EN];
        mode_r <= pwdata[3:0];
      end
      // the stretch beats a software release in the same cycle
      if (stretch) begin
        ckr_r <= 1'b0;
      end else if (wr && hit_c1) begin
        ckr_r <= pwdata[`C1_CKR];
      end
    end
  end

  // control two; requests refused while the engine runs
  wire c2_wr   = wr & hit_c2;
  wire c2_req  = c2_wr & ~active;
  wire sen_clr = (mst_r == M_START) & ph_end;
  wire ack_clr = (mst_r == M_ACK_HI) & ph_end;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gcen_r    <= 1'b0;
      ackstat_r <= 1'b0;
      ack_data_value_r   <= 1'b0;
      acken_r   <= 1'b0;
      rcen_r    <= 1'b0;
      pen_r     <= 1'b0;
      rsen_r    <= 1'b0;
      sen_r     <= 1'b0;
    end else begin
      if (c2_wr) begin
        gcen_r    <= pwdata[`C2_GCEN];
        ackstat_r <= pwdata[`C2_ACKSTAT];
        ack_data_value_r   <= pwdata[`C2_ACK_DATA_VALUE];
      end
      if (c2_req) begin
        rcen_r <= pwdata[`C2_RCEN];
        pen_r  <= pwdata[`C2_PEN];
        rsen_r <= pwdata[`C2_RSEN];
      end
      acken_r <= ack_clr ? 1'b0 : (c2_req ? pwdata[`C2_ACKEN] : acken_r);
      sen_r   <= sen_clr ? 1'b0 : (c2_req ? pwdata[`C2_SEN] : sen_r);
    end
  end

  // control three; the status bit is never taken from the bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      con3_r      <= 7'h00;
      ack_phase_r <= 1'b0;
    end else begin
      if (wr && hit_c3) begin
        con3_r <= pwdata[6:0];
      end
      if (!slave_m) begin
        ack_phase_r <= 1'b0;
      end else if (fall8 && (address_stretch_enable || data_stretch_enable)) begin
        ack_phase_r <= 1'b1;
      end else if (rise9 || start_det || stop_det) begin
        ack_phase_r <= 1'b0;
      end
    end
  end

  // master start and acknowledge sequencer
  logic mscl_hold_r;
  wire  [9:0] hold_cyc = data_hold_select ? 10'(`HOLD_LONG_CYC) : 10'(`HOLD_SHORT_CYC);

  always_comb begin
    mst_nxt = mst_r;
    unique case (mst_r)
      M_IDLE:   if (master_m && sen_r) mst_nxt = M_START;
                else if (master_m && acken_r) mst_nxt = M_ACK_LO;
      M_START:  if (ph_end) mst_nxt = M_IDLE;
      M_ACK_LO: if (ph_end) mst_nxt = M_ACK_HI;
      M_ACK_HI: if (ph_end) mst_nxt = M_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mst_r       <= M_IDLE;
      ph_cnt_r    <= 10'h000;
      mscl_hold_r <= 1'b0;
    end else begin
      mst_r       <= master_m ? mst_nxt : M_IDLE;
      ph_cnt_r    <= (mst_nxt != mst_r || !master_m) ? 10'h000 : ph_cnt_r + 10'h001;
      mscl_hold_r <= master_m & (mscl_hold_r | sen_clr);
    end
  end

  // pin drive; a zero clock release stretches the bus clock in slave mode
  wire m_sda_low = (mst_r == M_START)
                 | ((mst_r == M_ACK_LO) & (ph_cnt_r >= hold_cyc) & ~ack_data_value_r)
                 | ((mst_r == M_ACK_HI) & ~ack_data_value_r);
  wire m_scl_low = (mst_r == M_ACK_LO) | ((mst_r == M_IDLE) & mscl_hold_r);
  wire scl_low   = (slave_m & ~ckr_r) | m_scl_low;
  wire sda_low   = (slave_m & sda_low_r) | m_sda_low;

  assign serial_clock_line_out  = 1'b0;
  assign serial_clock_line_oe_n = ~scl_low;
  assign serial_data_line_out   = 1'b0;
  assign serial_data_line_oe_n  = ~sda_low;

  // interrupts; MODE_SL10_SS and MODE_SL10 ignore the enables, MODE_SL7_SS does not
  wire start_en = ss_mode | con3_r[`C3_START_IRQ_ENABLE];
  wire stop_en  = ss_mode | con3_r[`C3_PCIE];
  wire [3:0] irq_ev;
  assign irq_ev[`IRQ_START] = i2c_m & start_det & start_en;
  assign irq_ev[`IRQ_STOP]  = i2c_m & stop_det & stop_en;
  assign irq_ev[`IRQ_BYTE]  = fall8 | spi_done;
  assign irq_ev[`IRQ_COLL]  = coll_ev;
  wire [3:0] irq_w1c = (wr & hit_is) ? pwdata[3:0] : `RST_NIB;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_r <= `RST_NIB;
      irq_mask_r <= `RST_NIB;
    end else begin
      irq_stat_r <= irq_ev | (irq_stat_r & ~irq_w1c);
      if (wr && hit_im) begin
        irq_mask_r <= pwdata[3:0];
      end
    end
  end
  assign irq = |(irq_stat_r & irq_mask_r);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_start_self_clear: assert property ($rose(sen_r) |-> ##[1:600] !sen_r)
    else $error("start request never cleared");
  a_ack_data_out: assert property ((mst_r == M_ACK_HI) |-> serial_data_line_oe_n == ack_data_value_r)
    else $error("ack sequence drives wrong value");
  a_refuse_busy: assert property (active && c2_wr && pwdata[`C2_SEN] && !sen_r |=> !sen_r)
    else $error("request taken while busy");
  a_ack_phase_set: assert property (fall8 && (address_stretch_enable || data_stretch_enable) |=> ack_phase_r)
    else $error("ack phase status not set");
  a_ack_phase_clr: assert property (rise9 |=> !ack_phase_r)
    else $error("ack phase status not cleared");
  a_ack_idle_mode: assert property (!slave_m ##1 !slave_m |-> !ack_phase_r)
    else $error("ack phase status set outside slave");
  a_stop_irq: assert property (i2c_m && stop_det && stop_en |=> irq_stat_r[`IRQ_STOP])
    else $error("stop interrupt missed");
  a_start_irq: assert property (i2c_m && start_det && ss_mode |=> irq_stat_r[`IRQ_START])
    else $error("start interrupt missed");
  a_spi_keep: assert property (spi_done && full_r && !buffer_overwrite_enable && !buf_wr |=> $stable(buf_r) && ovf_r)
    else $error("spi buffer overwritten");
  a_hold_time: assert property (fall_any |=> $stable(serial_data_line_oe_n)[*8])
    else $error("data line changed inside hold");
  a_addr_stretch: assert property (fall8 && addr_ph_r && address_stretch_enable |=> !ckr_r && !serial_clock_line_oe_n)
    else $error("address hold did not stretch");
  a_data_stretch: assert property (fall8 && !addr_ph_r && data_stretch_enable |=> !ckr_r)
    else $error("data hold did not clear release");

endmodule : ssp_ctrl

// ### sim/link_host_model.sv
/*
  far side of the serial port: an i2c bus master and an spi master on the pins.
  assumes the bench resolves the open-drain lines from every party's drive.
*/
`timescale 1ns/1ps
module link_host_model (
  // resolved clock line
  input  wire logic scl,
  // open-drain drives, 1 = released
  output logic      scl_o,
  output logic      sda_o,
  // spi lines
  output logic      sck,
  output logic      sdi
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
    sck   = 1'b0;
    sdi   = 1'b0;
  end
  // works from idle and as a repeated start from a low clock
  task automatic start_c;
    sda_o = 1'b1;
    #80 scl_o = 1'b1;
    #80 sda_o = 1'b0;
    #80 scl_o = 1'b0;
  endtask : start_c
  task automatic stop_c;
    sda_o = 1'b0;
    #80 scl_o = 1'b1;
    #80 sda_o = 1'b1;
  endtask : stop_c
  // a stretched clock is waited out, bounded so a stuck port cannot hang us
  task automatic bit_c(input logic b);
    int n;
    sda_o = b;
    #80 scl_o = 1'b1;
    n = 0;
    while (scl !== 1'b1 && n < 9000) begin
      #10 n++;
    end
    #80 scl_o = 1'b0;
  endtask : bit_c
  task automatic byte_c(input logic [7:0] d);
    for (int i = 7; i >= 0; i--) bit_c(d[i]);
  endtask : byte_c
  // sck stands still between bytes; sdi then shows the inverse of its last bit
  task automatic spi_c(input logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      sdi = d[i];
      #80 sck = 1'b1;
      #80 sck = 1'b0;
    end
    sdi = ~d[0];
  endtask : spi_c
endmodule : link_host_model

// ### sim/tb.sv
/*
  bench of the serial port core: register rows, i2c slave, master, spi receive.
  assumes the link host model on the pins and PHASE_CYC of 20.
*/
`timescale 1ns/1ps
`include "ssp_consts.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb;
  typedef struct packed {logic [11:0] i; logic [7:0] d; logic [7:0] e; logic x;} row_t;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0]  rd;
  logic        scl_oe_n, sda_oe_n, scl_o, sda_o, sck, sdi, sdo;
  wire         scl = scl_oe_n & scl_o;
  wire         sda = sda_oe_n & sda_o;
  int          miscompares = 0;
  int          tests_run = 0;
  int          n;
  row_t        rows [4] = '{{`IDX_CON3, 8'hff, 8'h7f, 1'b0}, {`IDX_CON3, 8'h5a, 8'h5a, 1'b0},
                            {12'h1ff, 8'h55, 8'h00, 1'b1}, {`IDX_CON3, 8'h00, 8'h00, 1'b0}};
  ssp_ctrl #(.PHASE_CYC(20)) u_ssp_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .serial_clock_line_in(scl),
    .serial_clock_line_out(), .serial_clock_line_oe_n(scl_oe_n), .serial_data_line_in(sda),
    .serial_data_line_out(), .serial_data_line_oe_n(sda_oe_n), .spi_sck(sck),
    .spi_sdi(sdi), .spi_sdo(sdo));
  link_host_model u_link_host_model (.scl(scl), .scl_o(scl_o), .sda_o(sda_o), .sck(sck),
    .sdi(sdi));
  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test
  // one idle edge first, so a release never meets the next request in one step
  task automatic apb(input logic w, input logic [11:0] i, input logic [7:0] d);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {i, 2'b00};
    pwdata  <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 50) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 50) miscompares++;
    rd = prdata[7:0];
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] i, input logic [7:0] d);
    apb(1'b1, i, d);
  endtask : wr
  task automatic rc(input logic [11:0] i, input logic [7:0] e);
    apb(1'b0, i, 8'h00);
    `CHK(rd, e)
  endtask : rc
  task automatic wt(input int c);
    repeat (c) @(posedge pclk);
  endtask : wt
  // sync delay of the pin adds a few cycles on top of the hold
  task automatic ack_delay(input int lo);
    n = 0;
    while (sda_oe_n !== 1'b0 && n < 99) begin
      @(posedge pclk);
      n++;
    end
    `CHK(n >= lo + 2 && n <= lo + 7, 1'b1)
  endtask : ack_delay
  task automatic frame(input logic [7:0] c1, input logic [7:0] c3, input logic [7:0] e);
    wr(`IDX_IRQ_STAT, 8'h0f);
    wr(`IDX_CON1, c1);
    wr(`IDX_CON3, c3);
    u_link_host_model.start_c();
    u_link_host_model.stop_c();
    wt(8);
    rc(`IDX_IRQ_STAT, e);
  endtask : frame
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    #600000;
    miscompares++;
    stop_test();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    wt(1);
    `CHK({irq, scl_oe_n, sda_oe_n}, 3'b011)
    rc(`IDX_CON3, `RST_BYTE);
    foreach (rows[r]) begin
      wr(rows[r].i, rows[r].d);
      `CHK(err, rows[r].x)
      rc(rows[r].i, rows[r].e);
    end
    wr(`IDX_CON1, 8'h36);
    wr(`IDX_CON3, 8'h22);
    wr(`IDX_IRQ_MASK, 8'h0f);
    u_link_host_model.start_c();
    wt(8);
    `CHK(irq, 1'b1)
    wr(`IDX_IRQ_MASK, 8'h00);
    wt(1);
    `CHK(irq, 1'b0)
    rc(`IDX_IRQ_STAT, 8'h01);
    u_link_host_model.byte_c(8'ha4);
    ack_delay(`HOLD_SHORT_CYC);
    rc(`IDX_CON3, 8'ha2);
    rc(`IDX_CON1, 8'h26);
    `CHK(scl_oe_n, 1'b0)
    wr(`IDX_CON1, 8'h36);
    wt(1);
    `CHK(scl_oe_n, 1'b1)
    u_link_host_model.bit_c(1'b1);
    wt(8);
    rc(`IDX_CON3, 8'h22);
    rc(`IDX_BUF, 8'ha4);
    wr(`IDX_CON3, 8'h29);
    u_link_host_model.byte_c(8'h5a);
    ack_delay(`HOLD_LONG_CYC);
    rc(`IDX_CON1, 8'h26);
    wr(`IDX_CON1, 8'h36);
    u_link_host_model.bit_c(1'b1);
    frame(8'h36, 8'h40, 8'h02);
    frame(8'h36, 8'h00, 8'h00);
    frame(8'h3f, 8'h00, 8'h03);
    wr(`IDX_CON1, 8'h28);
    wr(`IDX_CON2, 8'h01);
    wt(2);
    `CHK(sda_oe_n, 1'b0)
    wr(`IDX_CON2, 8'h10);
    rc(`IDX_CON2, 8'h01);
    wr(`IDX_BUF, 8'h33);
    rc(`IDX_CON1, 8'ha8);
    wt(30);
    rc(`IDX_CON2, 8'h00);
    rc(`IDX_CON3, 8'h00);
    for (int a = 0; a < 2; a++) begin
      wr(`IDX_CON2, {2'b00, a[0], 5'h10});
      wt(15);
      `CHK({scl_oe_n, sda_oe_n}, {1'b0, a[0]})
      wt(30);
    end
    for (int b = 0; b < 2; b++) begin
      wr(`IDX_CON1, 8'h20);
      wr(`IDX_CON3, b ? 8'h00 : 8'h10);
      wr(`IDX_BUF, 8'h80);
      wt(1);
      `CHK(sdo, 1'b1)
      u_link_host_model.spi_c(8'(8'h11 + b));
      u_link_host_model.spi_c(8'(8'h21 + b));
      wt(8);
      `CHK(sdo, 1'b0)
      rc(`IDX_BUF, b ? 8'h12 : 8'h21);
      rc(`IDX_CON1, 8'h60);
    end
    stop_test();
  end
endmodule : tb
